// File: design/io_bit_pkg.sv
package io_bit_pkg;
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned BIT_W = 3;
    localparam int unsigned NUM_REGS = 64;
    localparam logic [ADDR_W-1:0] BIT_ADDR_MAX = 6'h1F;
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_READ_BYTE = 3'b001,
        OP_WRITE_BYTE = 3'b010,
        OP_BIT_SET = 3'b011,
        OP_BIT_CLEAR = 3'b100,
        OP_SKIP_IF_SET = 3'b101,
        OP_SKIP_IF_CLEAR = 3'b110
    } op_type;

    typedef struct packed {
        op_type op;
        logic [ADDR_W-1:0] addr;
        logic [BIT_W-1:0] bit_sel;
        logic [DATA_W-1:0] wdata;
    } req_type;

    typedef struct packed {
        logic valid;
        logic refused;
        logic skip;
        logic [DATA_W-1:0] rdata;
    } rsp_type;
endpackage

// File: design/io_bit_mask_gen.sv
`timescale 1ns/1ps
`default_nettype none
module io_bit_mask_gen (
    input wire logic [io_bit_pkg::BIT_W-1:0] bit_sel_i,
    output logic [io_bit_pkg::DATA_W-1:0] mask_o
);
    localparam int unsigned BW = io_bit_pkg::BIT_W;

    // One-hot decode, one bit per lane.
    for (genvar g = 0; g < io_bit_pkg::DATA_W; g++) begin : g_lane
        assign mask_o[g] = (bit_sel_i == BW'(g));
    end
endmodule
`default_nettype wire

// File: design/io_register_bit_access.sv
`timescale 1ns/1ps
`default_nettype none
module io_register_bit_access (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire io_bit_pkg::req_type req_i,
    input wire logic [io_bit_pkg::NUM_REGS*io_bit_pkg::DATA_W-1:0] w1c_mask_i,
    input wire logic [io_bit_pkg::NUM_REGS*io_bit_pkg::DATA_W-1:0] flag_set_i,
    output io_bit_pkg::rsp_type rsp_o,
    output logic [io_bit_pkg::NUM_REGS*io_bit_pkg::DATA_W-1:0] regs_o
);
    localparam int unsigned DW = io_bit_pkg::DATA_W;

    ////////////////////////////////////////////////////////////////////////////
    logic [DW-1:0] mem_q [io_bit_pkg::NUM_REGS];
    logic [DW-1:0] mem_d [io_bit_pkg::NUM_REGS];
    io_bit_pkg::rsp_type rsp_q;
    io_bit_pkg::rsp_type rsp_d;
    logic [DW-1:0] bit_mask;
    logic [DW-1:0] cur;
    logic [DW-1:0] w1c;
    logic in_bit_range;

    io_bit_mask_gen u_mask (
        .bit_sel_i(req_i.bit_sel),
        .mask_o(bit_mask)
    );

    assign cur = mem_q[req_i.addr];
    assign w1c = w1c_mask_i[req_i.addr*DW +: DW];
    assign in_bit_range = (req_i.addr <= io_bit_pkg::BIT_ADDR_MAX);

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [DW-1:0] wr_val;
        logic [DW-1:0] wr_en;
        logic [DW-1:0] keep;
        wr_val = '0;
        wr_en = '0;
        keep = '0;
        rsp_d = '0;
        for (int r = 0; r < io_bit_pkg::NUM_REGS; r++) begin
            mem_d[r] = mem_q[r];
        end
        case (req_i.op)
            io_bit_pkg::OP_NONE: begin
            end
            io_bit_pkg::OP_READ_BYTE: begin
                rsp_d.valid = 1'b1;
                rsp_d.rdata = cur;
            end
            io_bit_pkg::OP_WRITE_BYTE: begin
                rsp_d.valid = 1'b1;
                wr_val = req_i.wdata;
                wr_en = {DW{1'b1}};
            end
            io_bit_pkg::OP_BIT_SET, io_bit_pkg::OP_BIT_CLEAR: begin
                rsp_d.valid = 1'b1;
                rsp_d.refused = !in_bit_range;
                if (in_bit_range) begin
                    wr_val = (req_i.op == io_bit_pkg::OP_BIT_SET) ? bit_mask : ~bit_mask;
                    wr_en = bit_mask;
                end
            end
            io_bit_pkg::OP_SKIP_IF_SET, io_bit_pkg::OP_SKIP_IF_CLEAR: begin
                rsp_d.valid = 1'b1;
                rsp_d.refused = !in_bit_range;
                rsp_d.rdata = cur;
                if (in_bit_range) begin
                    rsp_d.skip = ((cur & bit_mask) != '0) == (req_i.op == io_bit_pkg::OP_SKIP_IF_SET);
                end
            end
            default: begin
                rsp_d.valid = 1'b1;
                rsp_d.refused = 1'b1;
            end
        endcase
        // Flag lanes clear on a written one; plain lanes take the written value.
        // write one clears
        keep = (cur & ~wr_en) | (wr_en & ~w1c & wr_val) | (wr_en & w1c & cur & ~wr_val);
        mem_d[req_i.addr] = keep;
        // Hardware set of a flag wins over a clear in the same cycle.
        for (int r = 0; r < io_bit_pkg::NUM_REGS; r++) begin
            mem_d[r] = mem_d[r] | (flag_set_i[r*DW +: DW] & w1c_mask_i[r*DW +: DW]);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int r = 0; r < io_bit_pkg::NUM_REGS; r++) begin
                mem_q[r] <= io_bit_pkg::REG_RESET;
            end
            rsp_q <= '0;
        end else begin
            for (int r = 0; r < io_bit_pkg::NUM_REGS; r++) begin
                mem_q[r] <= mem_d[r];
            end
            rsp_q <= rsp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign rsp_o = rsp_q;
    for (genvar g = 0; g < io_bit_pkg::NUM_REGS; g++) begin : g_out
        assign regs_o[g*DW +: DW] = mem_q[g];
    end
endmodule
`default_nettype wire

// File: dv/io_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module io_core_model (
    input wire io_bit_pkg::req_type cmd_i,
    output io_bit_pkg::req_type req_o
);
    // core issues byte ops above range.
    assign req_o = cmd_i;
endmodule
`default_nettype wire

// File: dv/io_bit_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module io_bit_asserts (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire io_bit_pkg::req_type req_i,
    input wire logic [511:0] w1c_mask_i,
    input wire logic [511:0] flag_set_i,
    input wire io_bit_pkg::rsp_type rsp_o,
    input wire logic [511:0] regs_o
);
    logic [9:0] h_q;
    wire logic [8:0] i = {req_i.addr, req_i.bit_sel};
    wire logic q = flag_set_i == '0, w = w1c_mask_i[i], lo = req_i.addr <= io_bit_pkg::BIT_ADDR_MAX;
    wire logic st = req_i.op == io_bit_pkg::OP_BIT_SET, cl = req_i.op == io_bit_pkg::OP_BIT_CLEAR;
    wire logic sk = req_i.op == io_bit_pkg::OP_SKIP_IF_SET;
    wire logic bo = st || cl || sk || req_i.op == io_bit_pkg::OP_SKIP_IF_CLEAR;
    // The bit index and its old value are held so the next cycle can judge them.
    always_ff @(posedge clk_i) h_q <= {i, regs_o[i]};
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    set_bit_a: assert property (st && lo && q && !w |=> regs_o[h_q[9:1]]) else $error("bit not set");
    clear_bit_a: assert property (cl && lo && q && !w |=> !regs_o[h_q[9:1]]) else $error("bit not cleared");
    skip_bit_a: assert property (sk && lo |=> rsp_o.valid && rsp_o.skip == h_q[0]) else $error("wrong skip");
    flag_clear_a: assert property (st && lo && q && w |=> !regs_o[h_q[9:1]]) else $error("flag kept");
    others_kept_a: assert property ((st || cl) && lo && q |=>
        ((regs_o ^ $past(regs_o)) & ~(512'h1 << h_q[9:1])) == '0) else $error("other bit changed");
    high_refused_a: assert property (bo && !lo && q |=> rsp_o.refused && $stable(regs_o)) else $error("not refused");
    cover property (rsp_o.refused);
    cover property (rsp_o.skip);
    cover property (st && lo && w);
endmodule
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_i = 1'b0, resetn_i = 1'b0;
    logic [511:0] flags = '0, regs;
    io_bit_pkg::req_type cmd = '0, req;
    io_bit_pkg::rsp_type rsp;
    int fails = 0, n_tests = 0;
    initial forever #5 clk_i = ~clk_i;
    io_core_model u_io_core_model (.cmd_i(cmd), .req_o(req));
    io_register_bit_access u_io_register_bit_access (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req),
        .w1c_mask_i(512'hFF << 40), .flag_set_i(flags), .rsp_o(rsp), .regs_o(regs));
    task automatic op(input logic [2:0] o, logic [5:0] a, logic [2:0] b, logic [7:0] w, logic [10:0] e);
        @(posedge clk_i) cmd <= {o, a, b, w};
        @(posedge clk_i) cmd.op <= io_bit_pkg::OP_NONE;
        #1 n_tests++;
        if ({regs[a*8+:8], rsp[10:8]} !== e) begin
            fails++;
            $display("unexpected at %0t got %h expected %h", $time, {regs[a*8+:8], rsp[10:8]}, e);
        end
    endtask
    task automatic t_bits();
        op(3'h3, 6'h03, 3'h2, 8'h00, {8'h04, 3'h4});
        op(3'h3, 6'h1F, 3'h7, 8'h00, {8'h80, 3'h4});
        op(3'h4, 6'h03, 3'h2, 8'h00, {8'h00, 3'h4});
        op(3'h5, 6'h1F, 3'h7, 8'h00, {8'h80, 3'h5});
        op(3'h6, 6'h1F, 3'h7, 8'h00, {8'h80, 3'h4});
        op(3'h3, 6'h20, 3'h0, 8'h00, {8'h00, 3'h6});
        op(3'h2, 6'h20, 3'h0, 8'h5A, {8'h5A, 3'h4});
        op(3'h7, 6'h03, 3'h0, 8'h00, {8'h00, 3'h6});
        op(3'h1, 6'h20, 3'h0, 8'h00, {8'h5A, 3'h4});
        n_tests++;
        if (rsp.rdata !== 8'h5A) begin
            fails++;
            $display("unexpected at %0t got %h expected %h", $time, rsp.rdata, 8'h5A);
        end
    endtask
    task automatic t_reset();
        @(posedge clk_i) resetn_i <= 1'b0;
        @(posedge clk_i) resetn_i <= 1'b1;
        op(3'h1, 6'h20, 3'h0, 8'h00, {8'h00, 3'h4});
    endtask
    task automatic t_flags();
        @(posedge clk_i) flags <= 512'hFF << 40;
        @(posedge clk_i) flags <= '0;
        op(3'h3, 6'h05, 3'h1, 8'h00, {8'hFD, 3'h4});
        op(3'h2, 6'h05, 3'h0, 8'h0C, {8'hF1, 3'h4});
    endtask
    task automatic end_of_test();
        if (fails == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_bits();
        t_flags();
        t_reset();
        end_of_test();
    end
    initial begin
        #5000 fails++;
        end_of_test();
    end
endmodule
bind io_register_bit_access io_bit_asserts u_io_bit_asserts (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i),
    .w1c_mask_i(w1c_mask_i), .flag_set_i(flag_set_i), .rsp_o(rsp_o), .regs_o(regs_o));
`default_nettype wire
